/* logic/seqctl_pkg.sv */
// Shared constants and types for the channel sequencer and autocycle control
package seqctl_pkg;

    // Register byte addresses
    localparam logic [15:0] ADDR_SEQUENCER_CONTROL = 16'h0022;
    localparam logic [15:0] ADDR_AUTOCYCLE_CONTROL = 16'h0023;
    localparam logic [15:0] ADDR_MASK_LO = 16'h0024;
    localparam logic [15:0] ADDR_MASK_HI = 16'h0025;

    // Reset values
    localparam logic [7:0] SEQUENCER_CONTROL_RST = 8'h80;
    localparam logic [7:0] AUTOCYCLE_CONTROL_RST = 8'h00;
    localparam logic [15:0] MASK_RST = 16'h0001;
    localparam logic [3:0] AC_RSVD_VAL = 4'h0;
    localparam logic [3:0] LAST_CHAN_RST = 4'hf;

    // Field positions
    localparam int STD_ON_BIT = 7;
    localparam int SLOTS_MSB = 6;
    localparam int AUTO_PERIOD_SELECT_MSB = 3;
    localparam int AUTO_PERIOD_SELECT_LSB = 1;
    localparam int AUTO_CONVERT_ON_BIT = 0;
    localparam int MASK_HI_LSB = 8;

    // Autocycle timing
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned AUTO_PERIOD_US [8] = '{10, 20, 40, 80, 100, 200, 400, 800};
    localparam int CNT_W = 20;

    typedef struct packed {
        logic std_on;
        logic [6:0] slots_m1;
        logic [2:0] period;
        logic auto_on;
        logic [15:0] mask;
    } regs_t;

    localparam regs_t REGS_RST = '{
        std_on: SEQUENCER_CONTROL_RST[STD_ON_BIT],
        slots_m1: SEQUENCER_CONTROL_RST[SLOTS_MSB:0],
        period: AUTOCYCLE_CONTROL_RST[AUTO_PERIOD_SELECT_MSB:AUTO_PERIOD_SELECT_LSB],
        auto_on: AUTOCYCLE_CONTROL_RST[AUTO_CONVERT_ON_BIT],
        mask: MASK_RST
    };

    typedef struct packed {
        logic start;
        logic [3:0] channel;
        logic [6:0] slot;
        logic adv;
    } conv_t;

    typedef struct packed {
        logic run;
        logic [CNT_W-1:0] cnt;
        logic tick;
    } timer_t;

    // Cycles in one autocycle period
    function automatic logic [CNT_W-1:0] period_cycles(input logic [2:0] code,
                                                       input int unsigned cyc_per_us);
        period_cycles = CNT_W'(AUTO_PERIOD_US[code] * cyc_per_us);
    endfunction

endpackage

/* logic/auto_period_timer.sv */
// Internal convert-start generator for autonomous conversion
`timescale 1ns/10ps
module auto_period_timer #(
    parameter int unsigned US_CYCLES = seqctl_pkg::CLK_MHZ
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic enable,
    input wire logic [2:0] period_sel,
    output logic tick
);
    seqctl_pkg::timer_t st_ff;
    seqctl_pkg::timer_t nxt_st;
    logic [seqctl_pkg::CNT_W-1:0] load;

    always_comb begin
        load = seqctl_pkg::period_cycles(period_sel, US_CYCLES) - 1'b1;
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!enable) begin
            nxt_st.run = 1'b0;
        end else if (!st_ff.run) begin
            nxt_st.run = 1'b1;
            nxt_st.cnt = load;
        end else if (st_ff.cnt == '0) begin
            nxt_st.tick = 1'b1;
            nxt_st.cnt = load;
        end else begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

    // Interval checker helpers
    logic [seqctl_pkg::CNT_W-1:0] gap_ff;
    logic gap_ok_ff;
    logic [2:0] sel_q_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_ff <= '0;
            gap_ok_ff <= 1'b0;
            sel_q_ff <= '0;
        end else if (ce) begin
            sel_q_ff <= period_sel;
            gap_ff <= st_ff.tick ? '0 : gap_ff + 1'b1;
            if (!enable || period_sel != sel_q_ff) begin
                gap_ok_ff <= 1'b0;
            end else if (st_ff.tick) begin
                gap_ok_ff <= 1'b1;
            end
        end
    end

    a_tick_spacing: assert property (@(posedge clk) disable iff (!nrst)
        ce && st_ff.tick && gap_ok_ff && period_sel == sel_q_ff
        |-> gap_ff == seqctl_pkg::period_cycles(period_sel, US_CYCLES) - 1'b1)
        else $error("autocycle tick spacing wrong");

    a_tick_needs_enable: assert property (@(posedge clk) disable iff (!nrst)
        !enable && ce |=> !st_ff.tick ##1 !st_ff.tick)
        else $error("autocycle tick while disabled");

endmodule

/* logic/channel_sequencer_autocycle_ctrl.sv */
// Channel sequencer configuration, conversion pointer and autocycle control
// Operation
// - Sequencer control bit 7 enables the standard sequencer and resets to enabled.
// - Sequencer control bits 6:0 give the advanced slot count as the field value plus one.
// - Autocycle control bits 3:1 select the period of the internal convert start.
// - Period codes 0 to 7 give 10, 20, 40, 80, 100, 200, 400 and 800 us.
// - Autocycle control bit 0 turns autonomous conversion on and resets to off.
// - Autocycle control bits 7:4 are read-only and read as zero.
// - Each set mask bit n puts input n in the standard sequence, bit 15 the highest.
// - The channel mask resets with only input 0 selected.
`timescale 1ns/10ps
module channel_sequencer_autocycle_ctrl #(
    parameter int unsigned US_CYCLES = seqctl_pkg::CLK_MHZ
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic CONV_REQ,
    output logic CONV_START,
    output logic [3:0] CHANNEL,
    output logic [6:0] SLOT,
    output logic ADV_ACTIVE,
    output logic STANDARD_SEQUENCER_ON,
    output logic [6:0] ADVANCED_SLOT_COUNT_MINUS_ONE,
    output logic [2:0] AUTO_PERIOD_SELECT,
    output logic AUTO_CONVERT_ON,
    output logic [15:0] CHANNEL_MASK,
    output logic CMD_MODE_ALLOWED
);
    typedef struct packed {
        seqctl_pkg::regs_t regs;
        logic [1:0] req_sync;
        logic req_q;
        logic [3:0] last_chan;
        logic [6:0] next_slot;
        seqctl_pkg::conv_t conv;
        logic [7:0] rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        regs: seqctl_pkg::REGS_RST,
        last_chan: seqctl_pkg::LAST_CHAN_RST,
        default: '0
    };

    state_t st_ff;
    state_t nxt_st;
    logic tick;
    logic req_edge;
    logic trigger;
    logic [3:0] ch;
    logic [6:0] sl;

    function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] target);
        reg_hit = (addr == target);
    endfunction

    // Next selected channel above cur, wrapping to the lowest
    function automatic logic [3:0] next_channel(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] res;
        logic [3:0] idx;
        logic found;
        res = cur;
        found = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            idx = cur + 4'(i);
            if (!found && mask[idx]) begin
                res = idx;
                found = 1'b1;
            end
        end
        next_channel = res;
    endfunction

    function automatic logic [7:0] read_byte(input seqctl_pkg::regs_t r, input logic [15:0] addr);
        read_byte = '0;
        if (reg_hit(addr, seqctl_pkg::ADDR_SEQUENCER_CONTROL)) begin
            read_byte = {r.std_on, r.slots_m1};
        end else if (reg_hit(addr, seqctl_pkg::ADDR_AUTOCYCLE_CONTROL)) begin
            read_byte = {seqctl_pkg::AC_RSVD_VAL, r.period, r.auto_on};
        end else if (reg_hit(addr, seqctl_pkg::ADDR_MASK_LO)) begin
            read_byte = r.mask[seqctl_pkg::MASK_HI_LSB-1:0];
        end else if (reg_hit(addr, seqctl_pkg::ADDR_MASK_HI)) begin
            read_byte = r.mask[15:seqctl_pkg::MASK_HI_LSB];
        end
    endfunction

    auto_period_timer #(
        .US_CYCLES(US_CYCLES)
    ) u_timer (
        .clk(MCLK),
        .nrst(NRST),
        .ce(CE),
        .enable(st_ff.regs.auto_on),
        .period_sel(st_ff.regs.period),
        .tick(tick)
    );

    assign req_edge = st_ff.req_sync[1] && !st_ff.req_q;
    // Autocycle owns convert start while on; the pin is ignored then
    assign trigger = st_ff.regs.auto_on ? tick : req_edge;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.conv.start = 1'b0;
        nxt_st.req_sync = {st_ff.req_sync[0], CONV_REQ};
        nxt_st.req_q = st_ff.req_sync[1];
        ch = next_channel(st_ff.regs.mask, st_ff.last_chan);
        sl = (st_ff.next_slot > st_ff.regs.slots_m1) ? '0 : st_ff.next_slot;
        if (trigger) begin
            nxt_st.conv.start = 1'b1;
            nxt_st.conv.adv = !st_ff.regs.std_on;
            if (st_ff.regs.std_on) begin
                nxt_st.conv.channel = ch;
                nxt_st.last_chan = ch;
            end else begin
                nxt_st.conv.slot = sl;
                nxt_st.next_slot = (sl == st_ff.regs.slots_m1) ? '0 : sl + 1'b1;
            end
        end
        if (REG_RD) begin
            nxt_st.rdata = read_byte(st_ff.regs, REG_ADDR);
        end
        if (REG_WR) begin
            if (reg_hit(REG_ADDR, seqctl_pkg::ADDR_SEQUENCER_CONTROL)) begin
                nxt_st.regs.std_on = REG_WDATA[seqctl_pkg::STD_ON_BIT];
                nxt_st.regs.slots_m1 = REG_WDATA[seqctl_pkg::SLOTS_MSB:0];
                // Any sequencer control write restarts both sequences
                nxt_st.last_chan = seqctl_pkg::LAST_CHAN_RST;
                nxt_st.next_slot = '0;
            end else if (reg_hit(REG_ADDR, seqctl_pkg::ADDR_AUTOCYCLE_CONTROL)) begin
                nxt_st.regs.period = REG_WDATA[seqctl_pkg::AUTO_PERIOD_SELECT_MSB:seqctl_pkg::AUTO_PERIOD_SELECT_LSB];
                nxt_st.regs.auto_on = REG_WDATA[seqctl_pkg::AUTO_CONVERT_ON_BIT];
            end else if (reg_hit(REG_ADDR, seqctl_pkg::ADDR_MASK_LO)) begin
                nxt_st.regs.mask[seqctl_pkg::MASK_HI_LSB-1:0] = REG_WDATA;
            end else if (reg_hit(REG_ADDR, seqctl_pkg::ADDR_MASK_HI)) begin
                nxt_st.regs.mask[15:seqctl_pkg::MASK_HI_LSB] = REG_WDATA;
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_ff <= STATE_RST;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA = st_ff.rdata;
    assign CONV_START = st_ff.conv.start;
    assign CHANNEL = st_ff.conv.channel;
    assign SLOT = st_ff.conv.slot;
    assign ADV_ACTIVE = st_ff.conv.adv;
    assign STANDARD_SEQUENCER_ON = st_ff.regs.std_on;
    assign ADVANCED_SLOT_COUNT_MINUS_ONE = st_ff.regs.slots_m1;
    assign AUTO_PERIOD_SELECT = st_ff.regs.period;
    assign AUTO_CONVERT_ON = st_ff.regs.auto_on;
    assign CHANNEL_MASK = st_ff.regs.mask;
    assign CMD_MODE_ALLOWED = (st_ff.regs.slots_m1 == '0);

    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);

    a_reset_defaults: assert property (
        !$past(NRST) |-> STANDARD_SEQUENCER_ON && !AUTO_CONVERT_ON
            && ADVANCED_SLOT_COUNT_MINUS_ONE == seqctl_pkg::SEQUENCER_CONTROL_RST[seqctl_pkg::SLOTS_MSB:0])
        else $error("control defaults wrong after reset");

    a_mask_reset: assert property (
        !$past(NRST) |-> CHANNEL_MASK == seqctl_pkg::MASK_RST)
        else $error("channel mask default wrong");

    a_std_bit_write: assert property (
        CE && REG_WR && REG_ADDR == seqctl_pkg::ADDR_SEQUENCER_CONTROL
        |=> STANDARD_SEQUENCER_ON == $past(REG_WDATA[seqctl_pkg::STD_ON_BIT])
            && ADVANCED_SLOT_COUNT_MINUS_ONE == $past(REG_WDATA[seqctl_pkg::SLOTS_MSB:0]))
        else $error("sequencer control write lost");

    a_slot_in_range: assert property (
        CE && trigger && !STANDARD_SEQUENCER_ON
        |=> ADV_ACTIVE && SLOT <= $past(ADVANCED_SLOT_COUNT_MINUS_ONE))
        else $error("advanced slot out of range");

    a_period_field: assert property (
        CE && REG_WR && REG_ADDR == seqctl_pkg::ADDR_AUTOCYCLE_CONTROL
        |=> AUTO_PERIOD_SELECT == $past(REG_WDATA[seqctl_pkg::AUTO_PERIOD_SELECT_MSB:seqctl_pkg::AUTO_PERIOD_SELECT_LSB])
            && AUTO_CONVERT_ON == $past(REG_WDATA[seqctl_pkg::AUTO_CONVERT_ON_BIT]))
        else $error("autocycle control write lost");

    a_auto_off_pin: assert property (
        CE && !AUTO_CONVERT_ON && req_edge |=> CONV_START)
        else $error("pin request not taken in manual mode");

    a_rsvd_read_zero: assert property (
        CE && REG_RD && REG_ADDR == seqctl_pkg::ADDR_AUTOCYCLE_CONTROL
        |=> REG_RDATA[7:4] == seqctl_pkg::AC_RSVD_VAL)
        else $error("reserved autocycle bits not zero");

    a_chan_selected: assert property (
        CE && trigger && STANDARD_SEQUENCER_ON && CHANNEL_MASK != '0
        |=> CONV_START && !ADV_ACTIVE && (($past(CHANNEL_MASK) >> CHANNEL) & 16'h0001) != '0)
        else $error("standard channel not in mask");

    a_chan_ascending: assert property (
        CE && trigger && STANDARD_SEQUENCER_ON && CHANNEL_MASK != '0
        |=> CHANNEL > $past(st_ff.last_chan)
            || (($past(CHANNEL_MASK) >> $past(st_ff.last_chan)) >> 1) == '0)
        else $error("standard sequence not ascending");

    a_adv_when_off: assert property (
        CONV_START |-> ADV_ACTIVE == !$past(STANDARD_SEQUENCER_ON, 1))
        else $error("advanced mode flag wrong");

endmodule

/* tb/host_model.sv */
// Host-side model issuing register byte accesses to the device
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr,
    output logic rd,
    output logic [15:0] addr,
    output logic [7:0] wdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
    end

    // One request cycle; afterwards address and data no longer hold
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        @(negedge clk);
        q = rdata;
        wr = 1'b0;
        rd = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
endmodule

/* tb/test_channel_sequencer_autocycle_ctrl.sv */
// Self-checking bench for the sequencer and autocycle control block
`timescale 1ns/10ps
module test_channel_sequencer_autocycle_ctrl;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic conv_req = 1'b0;
    logic reg_wr, reg_rd, conv_start, std_on, auto_on, adv_active, cmd_ok, ok;
    logic [15:0] reg_addr, chan_mask, mask;
    logic [7:0] reg_wdata, reg_rdata, q, seq, ac;
    logic [3:0] channel, last;
    logic [6:0] slot, slots_m1;
    logic [2:0] period_sel;
    logic [15:0] ra [4] = '{seqctl_pkg::ADDR_SEQUENCER_CONTROL, seqctl_pkg::ADDR_AUTOCYCLE_CONTROL,
                            seqctl_pkg::ADDR_MASK_LO, seqctl_pkg::ADDR_MASK_HI};
    int tbl [8] = '{10, 20, 40, 80, 100, 200, 400, 800};
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 32'h40da;
    int n, p, k;

    always #2.5 mclk = ~mclk;

    channel_sequencer_autocycle_ctrl #(.US_CYCLES(1)) dut_u (
        .MCLK(mclk), .NRST(nrst), .CE(ce), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .CONV_REQ(conv_req), .CONV_START(conv_start), .CHANNEL(channel), .SLOT(slot),
        .ADV_ACTIVE(adv_active), .STANDARD_SEQUENCER_ON(std_on),
        .ADVANCED_SLOT_COUNT_MINUS_ONE(slots_m1), .AUTO_PERIOD_SELECT(period_sel),
        .AUTO_CONVERT_ON(auto_on), .CHANNEL_MASK(chan_mask), .CMD_MODE_ALLOWED(cmd_ok)
    );

    host_model host_u (
        .clk(mclk), .rdata(reg_rdata), .wr(reg_wr), .rd(reg_rd),
        .addr(reg_addr), .wdata(reg_wdata)
    );

    task automatic conclude();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        host_u.access(1'b1, ra[i], d, q);
    endtask

    task automatic rd_check(input logic [15:0] a, input logic [7:0] e);
        host_u.access(1'b0, a, 8'h00, q);
        check(q, e);
    endtask

    // Pin request, then wait a bounded time for the start pulse
    task automatic convert(output logic got);
        int w;
        @(negedge mclk);
        conv_req = 1'b1;
        w = 0;
        while (conv_start !== 1'b1 && w < 8) begin
            @(negedge mclk);
            w++;
        end
        got = (conv_start === 1'b1);
        conv_req = 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    task automatic wait_pulse(output int w);
        w = 0;
        do begin
            @(negedge mclk);
            w++;
        end while (conv_start !== 1'b1 && w < 1000);
    endtask

    function automatic logic [3:0] next_chan(input logic [15:0] m, input logic [3:0] from);
        for (int i = 1; i <= 16; i++) begin
            if (m[4'(from + i)]) begin
                return 4'(from + i);
            end
        end
        return from;
    endfunction

    initial begin
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        rd_check(ra[0], 8'h80);
        rd_check(ra[1], 8'h00);
        rd_check(ra[2], 8'h01);
        rd_check(ra[3], 8'h00);
        rd_check(16'h0026, 8'h00);
        wr(1, 8'hfe);
        rd_check(ra[1], 8'h0e);
        check(period_sel, 3'h7);
        // Random round trips, slot field corners first
        for (n = 0; n < 24; n++) begin
            seq = 8'($random(seed));
            ac = 8'($random(seed)) & 8'hfe;
            mask = 16'($random(seed));
            if (n == 0) begin
                seq = 8'h7f;
            end else if (n == 1) begin
                seq = 8'h00;
            end
            wr(0, seq);
            wr(1, ac);
            wr(2, mask[7:0]);
            wr(3, mask[15:8]);
            rd_check(ra[0], seq);
            rd_check(ra[1], {4'h0, ac[3:0]});
            rd_check(ra[2], mask[7:0]);
            rd_check(ra[3], mask[15:8]);
            check(std_on, seq[7]);
            check(slots_m1, seq[6:0]);
            check(cmd_ok, seq[6:0] == 7'h00);
            check(period_sel, ac[3:1]);
            check(auto_on, 1'b0);
            check(chan_mask, mask);
        end
        // Standard order with wrap, sparse mask then random mask
        for (p = 0; p < 2; p++) begin
            mask = (p == 0) ? 16'h8421 : 16'($random(seed)) | 16'h0100;
            wr(2, mask[7:0]);
            wr(3, mask[15:8]);
            wr(0, 8'h80);
            last = 4'hf;
            for (n = 0; n < 7; n++) begin
                convert(ok);
                check(ok, 1'b1);
                last = next_chan(mask, last);
                check(channel, last);
                check(adv_active, 1'b0);
            end
        end
        wr(0, 8'h02);
        for (n = 0; n < 7; n++) begin
            convert(ok);
            check(adv_active, 1'b1);
            check(slot, 7'(n % 3));
        end
        wr(0, 8'h00);
        check(cmd_ok, 1'b1);
        // Autocycle period for every code
        for (n = 0; n < 8; n++) begin
            wr(1, 8'h00);
            wr(1, {4'h0, 3'(n), 1'b1});
            check(auto_on, 1'b1);
            wait_pulse(k);
            wait_pulse(k);
            check(k, tbl[n]);
        end
        wr(1, 8'h00);
        check(auto_on, 1'b0);
        // Clock enable low: a write must not land
        @(negedge mclk);
        ce = 1'b0;
        wr(2, ~mask[7:0]);
        check(chan_mask, mask);
        ce = 1'b1;
        // Mid-run reset restores defaults
        @(negedge mclk);
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        rd_check(ra[0], 8'h80);
        rd_check(ra[2], 8'h01);
        check(chan_mask, 16'h0001);
        check(auto_on, 1'b0);
        conclude();
    end
endmodule
